/* rtl/steer_pkg.sv */
package steer_pkg;
	// ----------------------------------------
	// Register map of the software port
	// ----------------------------------------
	localparam int REG_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// ----------------------------------------
	// Control word fields
	// ----------------------------------------
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 8;
	localparam int SIZE_LSB = 8;
	localparam int WDOG_DIS_BIT = 10;
	localparam int EXP_EN_BIT = 11;
	localparam int BMAP_LSB = 12;

	// ----------------------------------------
	// Status word fields
	// ----------------------------------------
	localparam int ST_EXP_EN = 0;
	localparam int ST_ATU = 1;
	localparam int ST_SLAVE = 2;
	localparam int ST_REF_PEND = 3;
	localparam int ST_ROW_LSB = 16;

	// ----------------------------------------
	// Physical address map
	// ----------------------------------------
	localparam int ADDR_W = 32;
	localparam int BUS_AW = 24;
	localparam logic [31:0] ROM_BASE = 32'h00FA_0000;
	localparam logic [31:0] BUS_IO_BASE = 32'h00FF_0000;
	localparam logic [31:0] LOCAL_TOP = 32'h0100_0000;
	localparam logic [31:0] SYS_WIN_BASE = 32'h0100_0000;
	localparam logic [31:0] EXP_WIN_BASE = 32'h0200_0000;
	localparam logic [31:0] WIN_END = 32'h0300_0000;
	localparam logic [31:0] SEL_REGION_END = 32'h0080_0000;
	localparam logic [31:0] RAM_256K = 32'h0004_0000;
	localparam logic [31:0] RAM_1M = 32'h0010_0000;
	localparam logic [31:0] RAM_4M = 32'h0040_0000;

	// ----------------------------------------
	// Memory cycle timing, in processor clocks
	// ----------------------------------------
	localparam int BASE_CYCLES = 3;
	localparam logic [1:0] WAIT_CPU = 2'h1;
	localparam logic [1:0] WAIT_ATU = 2'h2;
	localparam logic [1:0] WAIT_DMA = 2'h1;

	// ----------------------------------------
	// Refresh pacing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int REFRESH_HZ = 76_800;
	localparam int REFRESH_DIV = CLK_HZ / REFRESH_HZ;
	localparam int ROW_W = 10;
	localparam int PEND_W = 4;

	typedef enum logic [2:0] {
		ROUTE_RAM,
		ROUTE_ROM_IO,
		ROUTE_SYS_MEM,
		ROUTE_EXP_MEM,
		ROUTE_SYS_IO,
		ROUTE_FAULT
	} route_t;
endpackage

/* rtl/refresh_if.sv */
`timescale 1ns/1ps
interface refresh_if #(parameter int RW = 10);
	logic pending;
	logic grant;
	logic [RW-1:0] row;

	modport pacer (output pending, output row, input grant);
	modport user (input pending, input row, output grant);
endinterface

/* rtl/refresh_pacer.sv */
`timescale 1ns/1ps
module refresh_pacer
	import steer_pkg::*;
#(
	parameter int DIV = REFRESH_DIV,
	parameter int RW = ROW_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Refresh requests toward the arbiter
	refresh_if.pacer rif
);
	logic [15:0] div_cnt;
	logic tick;
	logic [PEND_W-1:0] owed;
	logic [RW-1:0] row;

	// ----------------------------------------
	// Refresh clock divider
	// ----------------------------------------
	assign tick = (div_cnt == 16'(DIV - 1));

	// One row falls due per refresh period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
		end else if (tick) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// ----------------------------------------
	// Owed rows and row address
	// ----------------------------------------
	// Debt builds while the RAM is held and drains back to back after
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			owed <= '0;
		end else if (tick && !rif.grant && owed != '1) begin
			owed <= owed + 1'b1;
		end else if (!tick && rif.grant) begin
			owed <= owed - 1'b1;
		end
	end

	// Next row after each refresh cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			row <= '0;
		end else if (rif.grant) begin
			row <= row + 1'b1;
		end
	end

	assign rif.pending = (owed != '0);
	assign rif.row = row;
endmodule

/* rtl/bus_memory_region_steering.sv */
// Operation
// - RAM top up to ROM base goes off-card
// - Megabytes two to eight follow select bits
// - First-megabyte bit covers RAM top onward
// - Expansion accesses need enable bit set first
// - Expansion bus disabled means driving nothing
// - Master only on expansion bus
// - Fixed windows reach each whole bus
// - Bus I/O region makes I/O cycles
// - Slave map places RAM per board
// - Refresh continues during bus accesses
// - Refresh resumes at once after watchdog
// - Plain processor RAM read takes four cycles
// - With translation unit five cycles
// - Pseudo-DMA RAM read takes four cycles
// - Three base cycles plus waits
// - Refresh one row per refresh period
// - Control word write-only, reset to zero
// - RAM block from zero sized by bits
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module bus_memory_region_steering
	import steer_pkg::*;
#(
	parameter int REF_DIV = REFRESH_DIV,
	parameter int RW = ROW_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Processor access
	input wire logic acc_req,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic acc_write,
	input wire logic acc_dma,
	output logic transfer_acknowledge_response,
	output logic acc_fault,
	// Steering outputs
	output logic ram_sel,
	output logic rom_io_sel,
	output logic sys_mem_cyc,
	output logic sys_io_cyc,
	output logic exp_mem_cyc,
	output logic exp_drive_en,
	output logic [BUS_AW-1:0] bus_addr,
	output logic bus_write,
	// Pins from the buses and board straps
	input wire logic bus_ack_pin,
	input wire logic address_translation_unit,
	input wire logic slave_req_pin,
	input wire logic [BUS_AW-1:0] slave_addr,
	output logic slave_ram_hit,
	// Watchdog from the bus controller
	input wire logic watchdog_expire,
	// DRAM refresh
	output logic refresh_strobe,
	output logic [RW-1:0] refresh_row
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RAM_WAIT,
		ST_BUS_WAIT,
		ST_LOCAL_WAIT,
		ST_DONE
	} state_t;

	logic rst_s1;
	logic rst_sync_n;
	logic [2:0] pin_raw;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_val;
	logic bus_ack;
	logic atu_fitted;
	logic slave_req;
	logic [15:0] ctrl;
	logic exp_en;
	logic [31:0] ram_top;
	state_t state;
	logic [1:0] wait_cnt;
	logic [1:0] next_wait;
	route_t route;
	logic slave_owns;
	logic dog_cut;
	logic ram_busy;
	logic take;
	logic fault_q;

	refresh_if #(.RW(RW)) rif ();

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Two-stage release of the asynchronous reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_sync_n <= rst_s1;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	assign pin_raw = {slave_req_pin, address_translation_unit, bus_ack_pin};

	// Four flops per pin: three in the chain, and the value, which moves once the last two agree
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			always_ff @(posedge mclk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					pin_s1[i] <= 1'b0;
					pin_s2[i] <= 1'b0;
					pin_s3[i] <= 1'b0;
					pin_val[i] <= 1'b0;
				end else begin
					pin_s1[i] <= pin_raw[i];
					pin_s2[i] <= pin_s1[i];
					pin_s3[i] <= pin_s2[i];
					if (pin_s2[i] == pin_s3[i]) begin
						pin_val[i] <= pin_s3[i];
					end
				end
			end
		end
	endgenerate

	assign bus_ack = pin_val[0];
	assign atu_fitted = pin_val[1];
	assign slave_req = pin_val[2];

	// ----------------------------------------
	// Control word
	// ----------------------------------------
	// Write-only word, cleared by reset
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl <= CTRL_RESET;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ctrl <= reg_wdata[15:0];
		end
	end

	assign exp_en = ctrl[EXP_EN_BIT];
	// Detached from the expansion bus until enabled
	assign exp_drive_en = exp_en;

	// On-card RAM block from address zero
	always_comb begin
		case (ctrl[SIZE_LSB +: 2])
			2'h1: ram_top = RAM_256K;
			2'h2: ram_top = RAM_1M;
			2'h3: ram_top = RAM_4M;
			default: ram_top = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Status readback one cycle after the strobe; control reads as zero
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd && reg_addr == REG_STATUS) begin
			reg_rdata <= 32'h0000_0000;
			reg_rdata[ST_EXP_EN] <= exp_en;
			reg_rdata[ST_ATU] <= atu_fitted;
			reg_rdata[ST_SLAVE] <= slave_owns;
			reg_rdata[ST_REF_PEND] <= rif.pending;
			reg_rdata[ST_ROW_LSB +: RW] <= rif.row;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		if (acc_addr < ram_top) begin
			route = ROUTE_RAM;
		end else if (acc_addr < SEL_REGION_END) begin
			// Megabyte select bit picks the bus
			if (ctrl[SEL_LSB + 32'(acc_addr[22:20])]) begin
				route = exp_en ? ROUTE_EXP_MEM : ROUTE_FAULT;
			end else begin
				route = ROUTE_SYS_MEM;
			end
		end else if (acc_addr < ROM_BASE) begin
			route = ROUTE_SYS_MEM;
		end else if (acc_addr < BUS_IO_BASE) begin
			route = ROUTE_ROM_IO;
		end else if (acc_addr < LOCAL_TOP) begin
			route = ROUTE_SYS_IO;
		end else if (acc_addr < EXP_WIN_BASE) begin
			route = ROUTE_SYS_MEM;
		end else if (acc_addr < WIN_END) begin
			route = exp_en ? ROUTE_EXP_MEM : ROUTE_FAULT;
		end else begin
			route = ROUTE_FAULT;
		end
	end

	// Inserted waits by requester and translation unit
	always_comb begin
		if (acc_dma) begin
			next_wait = WAIT_DMA;
		end else if (atu_fitted) begin
			next_wait = WAIT_ATU;
		end else begin
			next_wait = WAIT_CPU;
		end
	end

	// ----------------------------------------
	// Slave access from the system bus
	// ----------------------------------------
	// Only system bus requests hit board RAM, in its window
	assign slave_ram_hit = slave_req && (slave_addr[23:20] == ctrl[BMAP_LSB +: 4])
		&& (32'(slave_addr[19:0]) < ram_top);

	// Watchdog cut ends a long hold on the RAM
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dog_cut <= 1'b0;
		end else if (!slave_req) begin
			dog_cut <= 1'b0;
		end else if (watchdog_expire && !ctrl[WDOG_DIS_BIT]) begin
			dog_cut <= 1'b1;
		end
	end

	assign slave_owns = slave_ram_hit && !dog_cut;

	// ----------------------------------------
	// Refresh arbitration
	// ----------------------------------------
	// Only RAM cycles hold refresh off; bus cycles do not
	assign ram_busy = (state == ST_RAM_WAIT) || slave_owns;
	assign rif.grant = rif.pending && !ram_busy;

	// Registered refresh cycle and row
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			refresh_strobe <= 1'b0;
			refresh_row <= '0;
		end else begin
			refresh_strobe <= rif.grant;
			if (rif.grant) begin
				refresh_row <= rif.row;
			end
		end
	end

	refresh_pacer #(
		.DIV(REF_DIV),
		.RW(RW)
	) u_pacer (
		.mclk(mclk),
		.rst_n(rst_sync_n),
		.rif(rif)
	);

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// RAM requests wait out refresh and slave ownership
	assign take = (state == ST_IDLE) && acc_req
		&& !(route == ROUTE_RAM && (rif.grant || slave_owns));

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
			wait_cnt <= 2'h0;
			fault_q <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						fault_q <= (route == ROUTE_FAULT);
						case (route)
							ROUTE_RAM: begin
								// Three base cycles plus waits
								wait_cnt <= next_wait;
								state <= ST_RAM_WAIT;
							end
							ROUTE_ROM_IO: state <= ST_LOCAL_WAIT;
							ROUTE_FAULT: state <= ST_DONE;
							default: state <= ST_BUS_WAIT;
						endcase
					end
				end
				ST_RAM_WAIT: begin
					if (wait_cnt == 2'h0) begin
						state <= ST_DONE;
					end else begin
						wait_cnt <= wait_cnt - 2'h1;
					end
				end
				ST_BUS_WAIT: begin
					if (bus_ack) begin
						state <= ST_DONE;
					end
				end
				ST_LOCAL_WAIT: state <= ST_DONE;
				ST_DONE: begin
					fault_q <= 1'b0;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign transfer_acknowledge_response = (state == ST_DONE);
	assign acc_fault = (state == ST_DONE) && fault_q;

	// ----------------------------------------
	// Steering outputs
	// ----------------------------------------
	// Selects held for the whole access, cleared at the acknowledge; exp_mem_cyc also drops as soon as the enable bit clears
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ram_sel <= 1'b0;
			rom_io_sel <= 1'b0;
			sys_mem_cyc <= 1'b0;
			sys_io_cyc <= 1'b0;
			exp_mem_cyc <= 1'b0;
			bus_addr <= '0;
			bus_write <= 1'b0;
		end else if (take) begin
			ram_sel <= (route == ROUTE_RAM);
			rom_io_sel <= (route == ROUTE_ROM_IO);
			sys_mem_cyc <= (route == ROUTE_SYS_MEM);
			sys_io_cyc <= (route == ROUTE_SYS_IO);
			exp_mem_cyc <= (route == ROUTE_EXP_MEM) && exp_en;
			bus_addr <= acc_addr[BUS_AW-1:0];
			bus_write <= acc_write;
		end else if (state == ST_DONE || !exp_en) begin
			if (state == ST_DONE) begin
				ram_sel <= 1'b0;
				rom_io_sel <= 1'b0;
				sys_mem_cyc <= 1'b0;
				sys_io_cyc <= 1'b0;
				bus_write <= 1'b0;
			end
			exp_mem_cyc <= 1'b0;
		end
	end
endmodule

/* tb/steer_checker_properties.sv */
`timescale 1ns/1ps
module steer_checker
	import steer_pkg::*;
#(
	parameter int REF_DIV = REFRESH_DIV
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Processor access
	input wire logic acc_write,
	input wire logic acc_dma,
	input wire logic address_translation_unit,
	input wire logic transfer_acknowledge_response,
	input wire logic acc_fault,
	// Steering and refresh
	input wire logic ram_sel,
	input wire logic rom_io_sel,
	input wire logic sys_mem_cyc,
	input wire logic sys_io_cyc,
	input wire logic exp_mem_cyc,
	input wire logic exp_drive_en,
	input wire logic [BUS_AW-1:0] bus_addr,
	input wire logic slave_req_pin,
	input wire logic refresh_strobe
);
	logic ack;
	logic [15:0] gap;
	assign ack = transfer_acknowledge_response;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Clocks since the last row, cleared while a board may own the RAM
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 16'h0000;
		end else if (refresh_strobe || slave_req_pin) begin
			gap <= 16'h0000;
		end else begin
			gap <= gap + 16'h0001;
		end
	end
	// Relations between the ports
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("acknowledge longer than one cycle");
	ram_plain_wait_a: assert property ($rose(ram_sel) && !acc_write &&
		(acc_dma || !address_translation_unit) |-> !ack [*2] ##1 ack)
		else $error("plain RAM read not four cycles");
	ram_atu_wait_a: assert property ($rose(ram_sel) && !acc_write &&
		!acc_dma && address_translation_unit |-> !ack [*3] ##1 ack)
		else $error("translated RAM read not five cycles");
	fault_no_cycle_a: assert property (acc_fault |-> ack &&
		!(sys_mem_cyc || exp_mem_cyc || sys_io_cyc)) else $error("fault with bus cycle");
	exp_quiet_a: assert property (!exp_drive_en |-> !exp_mem_cyc)
		else $error("expansion cycle while detached");
	one_target_a: assert property ($onehot0({ram_sel, rom_io_sel, sys_mem_cyc,
		sys_io_cyc, exp_mem_cyc})) else $error("two targets at once");
	io_region_a: assert property (sys_io_cyc |-> bus_addr[23:16] == 8'hFF)
		else $error("I/O cycle outside I/O region");
	ctrl_hidden_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_CTRL
		|-> reg_rdata == 32'h0000_0000) else $error("control word readable");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data without read");
	refresh_pace_a: assert property (gap <= 16'(2 * REF_DIV + 16))
		else $error("refresh row overdue");
	cover property ($rose(ram_sel));
	cover property ($rose(exp_mem_cyc));
	cover property (refresh_strobe);
endmodule

bind bus_memory_region_steering steer_checker #(.REF_DIV(REF_DIV)) steer_checker_i (
	.mclk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .acc_write, .acc_dma,
	.address_translation_unit, .transfer_acknowledge_response, .acc_fault, .ram_sel,
	.rom_io_sel, .sys_mem_cyc, .sys_io_cyc, .exp_mem_cyc, .exp_drive_en, .bus_addr,
	.slave_req_pin, .refresh_strobe
);

/* tb/bus_far_side.sv */
`timescale 1ns/1ps
module bus_far_side (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Cycles from the board
	input wire logic sys_mem_cyc,
	input wire logic sys_io_cyc,
	input wire logic exp_mem_cyc,
	input wire logic exp_drive_en,
	input wire logic [7:0] ack_delay,
	// Answer to the board
	output logic bus_ack_pin
);
	logic [7:0] cnt;
	// Slaves answer after ack_delay clocks; expansion slaves see only a driven bus
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			bus_ack_pin <= 1'b0;
		end else if (sys_mem_cyc || sys_io_cyc || (exp_mem_cyc && exp_drive_en)) begin
			cnt <= cnt + 8'h01;
			bus_ack_pin <= (cnt >= ack_delay);
		end else begin
			cnt <= 8'h00;
			bus_ack_pin <= 1'b0;
		end
	end
endmodule

/* tb/bus_memory_region_steering_tb_top.sv */
`timescale 1ns/1ps
module bus_memory_region_steering_tb_top
	import steer_pkg::*;
;
	localparam logic [5:0] R_RAM = 6'h20, R_ROM = 6'h10, R_SYS = 6'h08;
	localparam logic [5:0] R_IO = 6'h04, R_EXP = 6'h02, R_FLT = 6'h01;
	logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, acc_req = 1'b0;
	logic acc_write = 1'b0, acc_dma = 1'b0, atu = 1'b0, slave_req_pin = 1'b0;
	logic watchdog_expire = 1'b0, ack, acc_fault, ram_sel, rom_io_sel, sys_mem_cyc;
	logic sys_io_cyc, exp_mem_cyc, exp_drive_en, bus_write, bus_ack_pin, slave_ram_hit;
	logic refresh_strobe;
	logic [7:0] reg_addr = 8'h00, ack_delay = 8'h02;
	logic [31:0] reg_wdata = 32'h0, acc_addr = 32'h0, reg_rdata;
	logic [23:0] slave_addr = 24'h0, bus_addr;
	logic [9:0] refresh_row, r0, d;
	int err_total = 0, samples_checked = 0, n;
	logic [53:0] tab [18] = '{
		{16'h0A0A, 32'h0000_0100, R_RAM}, {16'h0A0A, 32'h0010_0000, R_EXP},
		{16'h0A0A, 32'h0020_0000, R_SYS}, {16'h0A0A, 32'h007F_FFF0, R_SYS},
		{16'h0A0A, 32'h0090_0000, R_SYS}, {16'h0A0A, 32'h00FA_0000, R_ROM},
		{16'h0A0A, 32'h00FF_0010, R_IO}, {16'h0A0A, 32'h0100_1234, R_SYS},
		{16'h0A0A, 32'h0200_5678, R_EXP}, {16'h0A0A, 32'h0300_0000, R_FLT},
		{16'h0901, 32'h0003_FFFC, R_RAM}, {16'h0901, 32'h0004_0000, R_EXP},
		{16'h0901, 32'h000F_FFF0, R_EXP}, {16'h0901, 32'h0010_0000, R_SYS},
		{16'h0BFF, 32'h003F_FFFC, R_RAM}, {16'h0BFF, 32'h0040_0000, R_EXP},
		{16'h0800, 32'h0000_0000, R_SYS}, {16'h0202, 32'h0015_0000, R_FLT}};

	always #5 mclk = ~mclk;

	bus_memory_region_steering #(.REF_DIV(20)) bus_memory_region_steering_i (
		.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_req,
		.acc_addr, .acc_write, .acc_dma, .transfer_acknowledge_response(ack), .acc_fault,
		.ram_sel, .rom_io_sel, .sys_mem_cyc, .sys_io_cyc, .exp_mem_cyc, .exp_drive_en,
		.bus_addr, .bus_write, .bus_ack_pin, .address_translation_unit(atu), .slave_req_pin,
		.slave_addr, .slave_ram_hit, .watchdog_expire, .refresh_strobe, .refresh_row);
	bus_far_side bus_far_side_i (.mclk, .rst_n, .sys_mem_cyc, .sys_io_cyc, .exp_mem_cyc,
		.exp_drive_en, .ack_delay, .bus_ack_pin);

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] w, input logic [31:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check("reg", reg_rdata & m, w);
		@(posedge mclk);
	endtask

	// One processor access, judged at its acknowledge
	task automatic acc(input logic [31:0] a, input logic dma, input logic [5:0] w, input int tot);
		int k;
		k = 0;
		acc_addr <= a;
		acc_write <= a[2];
		acc_dma <= dma;
		acc_req <= 1'b1;
		for (int i = 0; i < 300 && ack !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
			if (ram_sel === 1'b1) k++;
		end
		if (ack !== 1'b1) begin
			err_total++;
			test_done();
		end
		check("route", {ram_sel, rom_io_sel, sys_mem_cyc, sys_io_cyc, exp_mem_cyc, acc_fault}, w);
		if (!w[0]) check("addr", {bus_write, bus_addr}, a[24:0] & 25'h0FF_FFFF | {a[2], 24'h0});
		if (w == R_RAM && !a[2]) check("cycles", k + 1, tot);
		@(posedge mclk);
		acc_req <= 1'b0; // Held through the edge that samples the acknowledge
		repeat (6) @(posedge mclk);
	endtask

	task automatic strobes(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(posedge mclk);
			#1;
			if (refresh_strobe === 1'b1) n++;
		end
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(REG_CTRL, 32'h0, 32'hFFFF_FFFF);
		rd(8'h08, 32'h0, 32'hFFFF_FFFF);
		rd(REG_STATUS, 32'h0, 32'h3);
		foreach (tab[i]) begin
			wr(REG_CTRL, {16'h0, tab[i][53:38]});
			acc(tab[i][37:6], 1'b0, tab[i][5:0], 4);
		end
		check("drive", exp_drive_en, 0);
		wr(REG_CTRL, 32'h1A0A);
		rd(REG_STATUS, 32'h1, 32'h1);
		acc(32'h200, 1'b1, R_RAM, 4);
		ack_delay <= 8'h50;
		acc(32'h0020_0000, 1'b0, R_SYS, 4);
		ack_delay <= 8'h02;
		atu <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(REG_STATUS, 32'h2, 32'h2);
		acc(32'h300, 1'b0, R_RAM, 5);
		acc(32'h400, 1'b1, R_RAM, 4);
		#1 r0 = refresh_row;
		strobes(200);
		d = refresh_row - r0;
		check("rate", n >= 9 && n <= 11, 1);
		check("row", d, n[9:0]);
		@(posedge mclk);
		slave_addr <= 24'h20_0010;
		slave_req_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		#1 check("miss", slave_ram_hit, 0);
		@(posedge mclk);
		slave_addr <= 24'h10_0010;
		strobes(4);
		check("hit", slave_ram_hit, 1);
		strobes(100);
		check("held", n, 0);
		@(posedge mclk);
		watchdog_expire <= 1'b1;
		@(posedge mclk);
		watchdog_expire <= 1'b0;
		strobes(8);
		check("resume", n > 0, 1);
		@(posedge mclk);
		slave_req_pin <= 1'b0;
		test_done();
	end
endmodule
